// ---- core/rwss_pkg.sv ----
// Package with constants and types for the reset, watchdog and suspend sequencer
package rwss_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

  localparam int MS_CNT_W = 7;
  localparam logic [MS_CNT_W-1:0] POR_HOLD_MS         = 7'h01;
  localparam logic [MS_CNT_W-1:0] SEMI_SUSPEND_MS     = 7'h5F;
  localparam logic [MS_CNT_W-1:0] WATCHDOG_TIMEOUT_MS = 7'h08;
  localparam logic [MS_CNT_W-1:0] WDR_LENGTH_MS       = 7'h02;
  localparam logic [MS_CNT_W-1:0] WAKE_SETTLE_MS      = 7'h01;
  localparam logic [MS_CNT_W-1:0] MS_ONE              = 7'h01;
  localparam logic [MS_CNT_W-1:0] MS_ZERO             = 7'h00;

  // ----------------------------------------------------------------
  // I/O register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] ADDR_WD_RESTART = 8'h26;
  localparam logic [7:0] ADDR_STATUS     = 8'hFF;

  // Status and control fields
  localparam int STAT_RUN_BIT       = 0;
  localparam int STAT_IRQ_SENSE_BIT = 2;
  localparam int STAT_SUSPEND_BIT   = 3;
  localparam int STAT_POR_BIT       = 4;
  localparam int STAT_WDR_BIT       = 6;
  localparam logic [7:0] STAT_POR_VALUE  = 8'h11;
  localparam logic [7:0] STAT_WDR_VALUE  = 8'h41;
  localparam logic [7:0] STAT_WDR_KEEP   = 8'h10;
  localparam logic [7:0] STAT_WRITE_MASK = 8'h5D;

  // Interrupt enable bank
  localparam int IRQEN_BUS_RESET_BIT = 0;
  localparam logic [7:0] IRQEN_RESET = 8'h00;

  // CPU restart values
  localparam logic [13:0] PC_RESET  = 14'h0000;
  localparam logic [7:0]  PSP_RESET = 8'h00;
  localparam logic [7:0]  DSP_RESET = 8'h00;
  localparam logic [7:0]  READ_NONE = 8'h00;

  // Pin synchroniser lanes
  localparam int N_PINS         = 4;
  localparam int PIN_POR_N      = 0;
  localparam int PIN_OSC_STABLE = 1;
  localparam int PIN_BUS_RESET  = 2;
  localparam int PIN_USB_ACTIVE = 3;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR,
    ST_HOLD1,
    ST_SEMI,
    ST_RUN,
    ST_WDR,
    ST_SUSP,
    ST_WAKE
  } rwss_state_e;

endpackage

// ---- core/rwss_seq.sv ----
// Reset, watchdog and suspend sequencer top level
`timescale 1ns/1ps
`default_nettype none
module rwss_seq #(
  parameter int TICK_CYCLES = rwss_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Pins from outside the clock domain
  input  wire logic        por_n,
  input  wire logic        osc_stable,
  input  wire logic        usb_bus_reset,
  input  wire logic        usb_activity,
  // On-chip inputs
  input  wire logic        gpio_wake_irq,
  input  wire logic        cpu_global_ie,
  input  wire logic        cpu_instr_done,
  input  wire logic        bus_reset_ack,
  // CPU I/O register port
  input  wire logic [7:0]  io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output var  logic [7:0]  io_rdata,
  // CPU control
  output var  logic        cpu_reset,
  output var  logic        cpu_run,
  output var  logic [13:0] pc_start,
  output var  logic [7:0]  program_stack_pointer,
  output var  logic [7:0]  data_stack_pointer,
  output var  logic        irq_hold,
  output var  logic        bus_reset_irq,
  // Chip control
  output var  logic        usb_addr_clear,
  output var  logic        osc_enable,
  output var  logic        timers_enable,
  output var  logic        logic_powered,
  output var  logic [7:0]  status_control,
  output var  logic [7:0]  interrupt_enable_bank
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [rwss_pkg::N_PINS-1:0] pin_raw;
  logic [rwss_pkg::N_PINS-1:0] sync1;
  logic [rwss_pkg::N_PINS-1:0] sync2;
  logic [rwss_pkg::N_PINS-1:0] sync3;
  logic [rwss_pkg::N_PINS-1:0] pin_f;

  assign pin_raw = {usb_activity, usb_bus_reset, osc_stable, por_n};

  // A change is taken only once the second and third stages agree
  for (genvar i = 0; i < rwss_pkg::N_PINS; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (srst) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        sync3[i] <= 1'b0;
        pin_f[i] <= 1'b0;
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          pin_f[i] <= sync3[i];
        end
      end
    end
  end

  logic por_active;
  logic osc_ok;
  logic bus_reset_q;
  logic bus_reset_rise;

  assign por_active     = !pin_f[rwss_pkg::PIN_POR_N];
  assign osc_ok         = pin_f[rwss_pkg::PIN_OSC_STABLE];
  assign bus_reset_rise = pin_f[rwss_pkg::PIN_BUS_RESET] && !bus_reset_q;

  // Edge memory for the filtered bus reset level
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_reset_q <= 1'b0;
    end else begin
      bus_reset_q <= pin_f[rwss_pkg::PIN_BUS_RESET];
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic wr_status;
  logic wr_irqen;
  logic wr_restart;

  assign wr_status  = io_wr && (io_addr == rwss_pkg::ADDR_STATUS);
  assign wr_irqen   = io_wr && (io_addr == rwss_pkg::ADDR_IRQ_ENABLE);
  assign wr_restart = io_wr && (io_addr == rwss_pkg::ADDR_WD_RESTART);

  // ----------------------------------------------------------------
  // Timebases
  // ----------------------------------------------------------------
  rwss_pkg::rwss_state_e state;
  rwss_pkg::rwss_state_e next_state;

  logic                          seq_tick;
  logic                          wd_tick;
  logic                          seq_clear;
  logic                          wd_clear;
  logic [rwss_pkg::MS_CNT_W-1:0] seq_ms;
  logic [rwss_pkg::MS_CNT_W-1:0] wd_ms;
  logic                          wd_expire;

  // Any state change restarts the sequence timebase from zero
  assign seq_clear = (next_state != state) || (state == rwss_pkg::ST_SUSP)
                   || (state == rwss_pkg::ST_WAKE && !osc_ok);
  // Watchdog only runs while the CPU runs; stopped in suspend
  assign wd_clear  = wr_restart || (state != rwss_pkg::ST_RUN);

  rwss_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_seq_div (
    .clk   (clk),
    .srst  (srst),
    .clear (seq_clear),
    .tick  (seq_tick)
  );

  rwss_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_wd_div (
    .clk   (clk),
    .srst  (srst),
    .clear (wd_clear),
    .tick  (wd_tick)
  );

  // Millisecond count within the current sequence state
  always_ff @(posedge clk) begin
    if (srst || seq_clear) begin
      seq_ms <= rwss_pkg::MS_ZERO;
    end else if (seq_tick) begin
      seq_ms <= seq_ms + rwss_pkg::MS_ONE;
    end
  end

  // Watchdog counter: a restart write always wins over a tick.
  // Rollover wraps to zero at once, so the count never reaches the timeout value.
  always_ff @(posedge clk) begin
    if (srst || wd_clear || wd_expire) begin
      wd_ms <= rwss_pkg::MS_ZERO;
    end else if (wd_tick) begin
      wd_ms <= wd_ms + rwss_pkg::MS_ONE;
    end
  end

  // Rollover after exactly the timeout since the last clear
  assign wd_expire = wd_tick && !wd_clear
                   && (wd_ms == rwss_pkg::WATCHDOG_TIMEOUT_MS - rwss_pkg::MS_ONE);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic seq_done;
  logic wake_req;

  assign wake_req = gpio_wake_irq || pin_f[rwss_pkg::PIN_USB_ACTIVE];

  // Next state; power-on reset overrides every state
  always_comb begin
    next_state = state;
    seq_done   = 1'b0;
    case (state)
      rwss_pkg::ST_POR: begin
        if (!por_active && osc_ok) begin
          next_state = rwss_pkg::ST_HOLD1;
        end
      end
      rwss_pkg::ST_HOLD1: begin
        // First millisecond ignores bus resets
        if (seq_tick && seq_ms == rwss_pkg::POR_HOLD_MS - rwss_pkg::MS_ONE) begin
          next_state = rwss_pkg::ST_SEMI;
        end
      end
      rwss_pkg::ST_SEMI: begin
        if (bus_reset_rise) begin
          next_state = rwss_pkg::ST_RUN;
        end else if (seq_tick
                     && seq_ms == rwss_pkg::SEMI_SUSPEND_MS - rwss_pkg::MS_ONE) begin
          next_state = rwss_pkg::ST_RUN;
        end
      end
      rwss_pkg::ST_RUN: begin
        if (wd_expire) begin
          next_state = rwss_pkg::ST_WDR;
        end else if (wr_status && io_wdata[rwss_pkg::STAT_SUSPEND_BIT]) begin
          next_state = rwss_pkg::ST_SUSP;
        end
      end
      rwss_pkg::ST_WDR: begin
        if (seq_tick && seq_ms == rwss_pkg::WDR_LENGTH_MS - rwss_pkg::MS_ONE) begin
          next_state = rwss_pkg::ST_RUN;
        end
      end
      rwss_pkg::ST_SUSP: begin
        // Without the run bit the part cannot resume
        if (wake_req && status_control[rwss_pkg::STAT_RUN_BIT]) begin
          next_state = rwss_pkg::ST_WAKE;
        end
      end
      rwss_pkg::ST_WAKE: begin
        if (osc_ok && seq_tick
            && seq_ms == rwss_pkg::WAKE_SETTLE_MS - rwss_pkg::MS_ONE) begin
          next_state = rwss_pkg::ST_RUN;
          seq_done   = 1'b1;
        end
      end
      default: begin
        next_state = rwss_pkg::ST_POR;
      end
    endcase
    if (por_active) begin
      next_state = rwss_pkg::ST_POR;
      seq_done   = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= rwss_pkg::ST_POR;
    end else begin
      state <= next_state;
    end
  end

  logic next_in_reset;
  logic entering_wdr;
  logic entering_por;

  assign next_in_reset = (next_state == rwss_pkg::ST_POR) || (next_state == rwss_pkg::ST_HOLD1)
                       || (next_state == rwss_pkg::ST_SEMI) || (next_state == rwss_pkg::ST_WDR);
  assign entering_wdr  = (next_state == rwss_pkg::ST_WDR) && (state != rwss_pkg::ST_WDR);
  assign entering_por  = (next_state == rwss_pkg::ST_POR);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Status and control; hardware loads win over firmware writes
  always_ff @(posedge clk) begin
    if (srst || entering_por) begin
      status_control <= rwss_pkg::STAT_POR_VALUE;
    end else if (entering_wdr) begin
      status_control <= rwss_pkg::STAT_WDR_VALUE
                      | (status_control & rwss_pkg::STAT_WDR_KEEP);
    end else if (seq_done) begin
      status_control[rwss_pkg::STAT_SUSPEND_BIT] <= 1'b0;
    end else if (wr_status) begin
      status_control <= io_wdata & rwss_pkg::STAT_WRITE_MASK;
    end
  end

  // Interrupt enable bank; cleared by both reset sources
  always_ff @(posedge clk) begin
    if (srst || entering_por || entering_wdr) begin
      interrupt_enable_bank <= rwss_pkg::IRQEN_RESET;
    end else if (wr_irqen) begin
      interrupt_enable_bank <= io_wdata;
    end
  end

  // Registered read port; write-only and unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      io_rdata <= rwss_pkg::READ_NONE;
    end else if (io_rd) begin
      case (io_addr)
        rwss_pkg::ADDR_STATUS: begin
          io_rdata <= status_control;
        end
        rwss_pkg::ADDR_IRQ_ENABLE: begin
          io_rdata <= interrupt_enable_bank;
        end
        default: begin
          io_rdata <= rwss_pkg::READ_NONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt gating
  // ----------------------------------------------------------------
  logic bus_reset_pending;

  // Pending bus reset survives the end of semi-suspend; a new event beats the ack
  always_ff @(posedge clk) begin
    if (srst || entering_por || entering_wdr) begin
      bus_reset_pending <= 1'b0;
    end else if (bus_reset_rise && state != rwss_pkg::ST_POR) begin
      bus_reset_pending <= 1'b1;
    end else if (bus_reset_ack) begin
      bus_reset_pending <= 1'b0;
    end
  end

  // Hold interrupts off until the instruction after the suspend write retires
  always_ff @(posedge clk) begin
    if (srst || entering_por || entering_wdr) begin
      irq_hold <= 1'b0;
    end else if (seq_done) begin
      irq_hold <= 1'b1;
    end else if (cpu_instr_done) begin
      irq_hold <= 1'b0;
    end
  end

  // Request reaches the CPU only when both enables are set
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_reset_irq <= 1'b0;
    end else begin
      bus_reset_irq <= bus_reset_pending && !irq_hold && cpu_global_ie
                     && interrupt_enable_bank[rwss_pkg::IRQEN_BUS_RESET_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Outputs to CPU and chip
  // ----------------------------------------------------------------
  // Driven from next_state so outputs line up with the state register
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_reset      <= 1'b1;
      cpu_run        <= 1'b0;
      usb_addr_clear <= 1'b1;
      osc_enable     <= 1'b1;
      timers_enable  <= 1'b1;
      logic_powered  <= 1'b1;
    end else begin
      cpu_reset      <= next_in_reset;
      cpu_run        <= next_state == rwss_pkg::ST_RUN;
      usb_addr_clear <= next_in_reset;
      osc_enable     <= next_state != rwss_pkg::ST_SUSP;
      timers_enable  <= (next_state != rwss_pkg::ST_SUSP)
                     && (next_state != rwss_pkg::ST_WAKE);
      logic_powered  <= next_state != rwss_pkg::ST_SUSP;
    end
  end

  // Restart values stand while the CPU is held in reset
  always_ff @(posedge clk) begin
    if (srst || next_in_reset) begin
      pc_start              <= rwss_pkg::PC_RESET;
      program_stack_pointer <= rwss_pkg::PSP_RESET;
      data_stack_pointer    <= rwss_pkg::DSP_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_wdr_pattern;
    @(posedge clk) disable iff (srst)
    (state == rwss_pkg::ST_WDR && $past(state) != rwss_pkg::ST_WDR)
      |-> ((status_control & ~rwss_pkg::STAT_WDR_KEEP) == rwss_pkg::STAT_WDR_VALUE);
  endproperty
  a_wdr_pattern: assert property (p_wdr_pattern) else $error("wdr status pattern wrong");

  property p_restart_clears;
    @(posedge clk) disable iff (srst)
    wr_restart |=> (wd_ms == rwss_pkg::MS_ZERO);
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart left count");

  property p_wd_bound;
    @(posedge clk) disable iff (srst)
    wd_ms < rwss_pkg::WATCHDOG_TIMEOUT_MS;
  endproperty
  a_wd_bound: assert property (p_wd_bound) else $error("watchdog passed timeout");

  property p_wd_fires;
    @(posedge clk) disable iff (srst)
    (wd_expire && !por_active) |=> (state == rwss_pkg::ST_WDR) && cpu_reset && usb_addr_clear;
  endproperty
  a_wd_fires: assert property (p_wd_fires) else $error("rollover without reset");

  property p_halt_in_semi;
    @(posedge clk) disable iff (srst)
    (state == rwss_pkg::ST_SEMI || state == rwss_pkg::ST_HOLD1)
      |-> (!cpu_run && osc_enable && cpu_reset);
  endproperty
  a_halt_in_semi: assert property (p_halt_in_semi) else $error("cpu ran in semi-suspend");

  property p_bus_reset_abort;
    @(posedge clk) disable iff (srst)
    (state == rwss_pkg::ST_SEMI && bus_reset_rise && !por_active)
      |=> (cpu_run && bus_reset_pending && pc_start == rwss_pkg::PC_RESET);
  endproperty
  a_bus_reset_abort: assert property (p_bus_reset_abort) else $error("bus reset ignored");

  property p_wdr_length;
    @(posedge clk) disable iff (srst)
    (state == rwss_pkg::ST_WDR && seq_tick && !por_active
     && seq_ms == rwss_pkg::WDR_LENGTH_MS - rwss_pkg::MS_ONE) |=> cpu_run;
  endproperty
  a_wdr_length: assert property (p_wdr_length) else $error("wdr length wrong");

  property p_suspend_stops;
    @(posedge clk) disable iff (srst)
    (state == rwss_pkg::ST_SUSP) |-> (!osc_enable && !timers_enable && !logic_powered);
  endproperty
  a_suspend_stops: assert property (p_suspend_stops) else $error("clocks ran in suspend");

  property p_por_cause;
    @(posedge clk) disable iff (srst)
    (state == rwss_pkg::ST_POR) |-> status_control[rwss_pkg::STAT_POR_BIT];
  endproperty
  a_por_cause: assert property (p_por_cause) else $error("por cause not logged");

  property p_wake_hold;
    @(posedge clk) disable iff (srst)
    (state == rwss_pkg::ST_WAKE && $past(state) == rwss_pkg::ST_SUSP)
      |-> osc_enable ##1 (state != rwss_pkg::ST_RUN || irq_hold);
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake sequence wrong");

  c_bus_reset_abort: cover property (@(posedge clk) disable iff (srst)
    state == rwss_pkg::ST_SEMI && bus_reset_rise);
  c_wdr_entry: cover property (@(posedge clk) disable iff (srst) entering_wdr);
  c_wake: cover property (@(posedge clk) disable iff (srst) seq_done);

endmodule
`default_nettype wire

// ---- core/rwss_tick_div.sv ----
// Millisecond tick divider with synchronous restart
`timescale 1ns/1ps
`default_nettype none
module rwss_tick_div #(
  parameter int CYCLES = 100000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Control
  input  wire logic clear,
  // Tick out
  output var  logic tick
);

  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] ZERO = '0;

  logic [CW-1:0] cnt;

  // Restarting on clear keeps the first tick a full period away
  always_ff @(posedge clk) begin
    if (srst || clear) begin
      cnt  <= ZERO;
      tick <= 1'b0;
    end else if (cnt == LAST) begin
      cnt  <= ZERO;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + CW'(1);
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- testbench/rwss_cpu_model.sv ----
// CPU partner model that retires instructions and takes the bus reset interrupt
`timescale 1ns/1ps
`default_nettype none
module rwss_cpu_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // From the sequencer
  input  wire logic cpu_run,
  input  wire logic irq_hold,
  input  wire logic bus_reset_irq,
  // To the sequencer
  output var  logic cpu_instr_done,
  output var  logic bus_reset_ack
);
  // Looks just after each edge, so it sees settled registers; pulses last one cycle.
  // The reset handler runs straight on and never returns from call or interrupt.
  initial begin
    cpu_instr_done = 1'b0;
    bus_reset_ack  = 1'b0;
    forever begin
      @(posedge clk);
      #1;
      cpu_instr_done = !srst && cpu_run && irq_hold && !cpu_instr_done;
      bus_reset_ack  = !srst && bus_reset_irq && !bus_reset_ack;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the reset, watchdog and suspend sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int T = 20;
  logic        clk, srst, por_n, osc_stable, usb_bus_reset, usb_activity;
  logic        gpio_wake_irq, cpu_global_ie, cpu_instr_done, bus_reset_ack;
  logic        io_wr, io_rd, cpu_reset, cpu_run, irq_hold, bus_reset_irq;
  logic        usb_addr_clear, osc_enable, timers_enable, logic_powered;
  logic [7:0]  io_addr, io_wdata, io_rdata, status_control, interrupt_enable_bank;
  logic [7:0]  program_stack_pointer, data_stack_pointer;
  logic [13:0] pc_start;
  int          errors, comparisons, n;

  rwss_seq #(.TICK_CYCLES(T)) uut (.clk, .srst, .por_n, .osc_stable, .usb_bus_reset,
    .usb_activity, .gpio_wake_irq, .cpu_global_ie, .cpu_instr_done, .bus_reset_ack,
    .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .cpu_reset, .cpu_run, .pc_start,
    .program_stack_pointer, .data_stack_pointer, .irq_hold, .bus_reset_irq,
    .usb_addr_clear, .osc_enable, .timers_enable, .logic_powered, .status_control,
    .interrupt_enable_bank);

  rwss_cpu_model cpu (.clk, .srst, .cpu_run, .irq_hold, .bus_reset_irq, .cpu_instr_done,
    .bus_reset_ack);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register port: strobe held one cycle, released just after the taking edge
  task automatic io_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
    io_wr = 1'b0;
  endtask

  task automatic io_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1;
    io_rd = 1'b0;
    chk(14'(io_rdata), 14'(exp));
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return cpu_run;
      1: return osc_enable;
      default: return bus_reset_irq;
    endcase
  endfunction

  // Bounded wait on an output; the count lets callers check the delay
  task automatic wait_sig(input int k, input logic v, input int max, output int cnt);
    cnt = 0;
    while (pick(k) !== v && cnt < max) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk(14'(pick(k)), 14'(v));
  endtask

  task automatic do_reset();
    srst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {errors, comparisons} = '0;
    {srst, por_n, osc_stable} = 3'b111;
    {usb_bus_reset, usb_activity, gpio_wake_irq, cpu_global_ie, io_wr, io_rd} = '0;
    {io_addr, io_wdata} = '0;
    do_reset();
    chk(14'(status_control), 14'h11);
    chk(14'(interrupt_enable_bank), 14'h00);
    chk(pc_start, 14'h0000);
    chk(14'(program_stack_pointer | data_stack_pointer), 14'h0);
    chk(14'({cpu_run, usb_addr_clear, osc_enable, timers_enable}), 14'h7);
    wait_sig(0, 1'b1, 2100, n);
    chk(14'(n inside {[1915:1935]}), 14'h1);
    // Restarts spaced under the timeout keep the CPU running
    io_write(8'h20, 8'h01);
    io_read(8'h20, 8'h01);
    for (int i = 0; i < 3; i++) begin
      repeat (6 * T) @(posedge clk);
      io_write(8'h26, 8'(i * 85));
    end
    chk(14'(cpu_run), 14'h1);
    wait_sig(0, 1'b0, 200, n);
    chk(14'(n inside {[158:164]}), 14'h1);
    chk(14'({cpu_reset, usb_addr_clear}), 14'h3);
    wait_sig(0, 1'b1, 60, n);
    chk(14'(n inside {[37:45]}), 14'h1);
    chk(pc_start, 14'h0000);
    io_read(8'hFF, 8'h51);
    io_read(8'h20, 8'h00);
    io_read(8'h26, 8'h00);
    io_read(8'h55, 8'h00);
    // Suspend, then wake by USB activity and by a GPIO interrupt
    for (int k = 0; k < 2; k++) begin
      io_write(8'hFF, 8'h09);
      wait_sig(1, 1'b0, 3, n);
      chk(14'({timers_enable, logic_powered, cpu_run}), 14'h0);
      repeat (10 * T) @(posedge clk);
      #1;
      chk(14'(osc_enable), 14'h0);
      usb_activity = (k == 0);
      gpio_wake_irq = (k == 1);
      wait_sig(1, 1'b1, 6, n);
      wait_sig(0, 1'b1, T + 10, n);
      chk(14'(n inside {[T - 2:T + 8]}), 14'h1);
      chk(14'(irq_hold), 14'h1);
      usb_activity = 1'b0;
      gpio_wake_irq = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(14'(irq_hold), 14'h0);
      io_read(8'hFF, 8'h01);
    end
    // Without the run bit a wake event is ignored
    io_write(8'hFF, 8'h08);
    wait_sig(1, 1'b0, 3, n);
    usb_activity = 1'b1;
    repeat (T) @(posedge clk);
    #1;
    chk(14'(osc_enable), 14'h0);
    usb_activity = 1'b0;
    // Bus reset cuts the power-on wait short and stays pending
    do_reset();
    chk(14'(status_control), 14'h11);
    repeat (3 * T) @(posedge clk);
    #1;
    chk(14'(cpu_run), 14'h0);
    usb_bus_reset = 1'b1;
    wait_sig(0, 1'b1, 8, n);
    chk(pc_start, 14'h0000);
    chk(14'(bus_reset_irq), 14'h0);
    io_write(8'h20, 8'h01);
    repeat (3) @(posedge clk);
    #1;
    chk(14'(bus_reset_irq), 14'h0);
    cpu_global_ie = 1'b1;
    wait_sig(2, 1'b1, 4, n);
    wait_sig(2, 1'b0, 6, n);
    usb_bus_reset = 1'b0;
    results();
  end

  // Whole run needs about 3100 cycles; a hang is cut off well beyond that
  initial begin
    #200000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
